// [fiber_select_and_trigger_decision.sv]
// Fibre card selection, hit count flags and final trigger decision
//
// The placing of the registers and the AXI4-Lite slave port were left to the implementer.
`default_nettype none
module fiber_select_and_trigger_decision (
    input  wire logic        ref_clk,               // System clock 100 MHz
    input  wire logic        rst_n,                 // Async reset, low
    // AXI4-Lite slave
    input  wire logic [7:0]  awaddr,                // Write address
    input  wire logic        awvalid,               // Write address valid
    output logic             awready,               // Write address ready
    input  wire logic [31:0] wdata,                 // Write data
    input  wire logic [3:0]  wstrb,                 // Write byte strobes
    input  wire logic        wvalid,                // Write data valid
    output logic             wready,                // Write data ready
    output logic [1:0]       bresp,                 // Write response
    output logic             bvalid,                // Write response valid
    input  wire logic        bready,                // Write response ready
    input  wire logic [7:0]  araddr,                // Read address
    input  wire logic        arvalid,               // Read address valid
    output logic             arready,               // Read address ready
    output logic [31:0]      rdata,                 // Read data
    output logic [1:0]       rresp,                 // Read response
    output logic             rvalid,                // Read data valid
    input  wire logic        rready,                // Read data ready
    // Upstream distance cards
    input  wire logic [15:0] card_min_gap,          // Four 4-bit gaps
    input  wire logic [15:0] card_hit_count,        // Four 4-bit counts
    // Network cards and pattern flags
    input  wire logic [3:0]  net_verdict,           // Four verdicts
    input  wire logic        left_pos1_valid,       // Left pos 1 present
    input  wire logic        left_pos2_valid,       // Left pos 2 present
    input  wire logic        right_pos1_valid,      // Right pos 1 present
    input  wire logic        right_pos2_valid,      // Right pos 2 present
    input  wire logic        left_none_hit,         // Left empty
    input  wire logic        right_none_hit,        // Right empty
    input  wire logic        left_too_many,         // Left overflow
    input  wire logic        right_too_many,        // Right overflow
    // Outputs
    output logic [3:0]       card_pick,             // One-hot card select
    output logic             final_accept,          // Trigger decision
    output logic             input_buffer_enable_n, // Input buffer enable
    output logic             table_output_enable_n, // Table output enable
    output logic             picker_enable_n,       // Picker enable
    output logic             gap_table_write_n,     // Gap table write
    output logic             count_table_write_n    // Count table write
);
    // ------------------------------------------------------------
    // Registers and internal signals
    // ------------------------------------------------------------
    logic [3:0]  mode_r;          // Mode code and overflow enable
    logic [31:0] addr_r;          // Test address, gap low, count high
    logic [7:0]  data_r;          // Load data, gap low, count high
    logic [17:0] dtest_r;         // Decision test stimulus
    logic [2:0]  mode;
    logic        ovf_en;
    logic        aw_held_r;
    logic        w_held_r;
    logic [7:0]  awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic        wr_go;
    logic [31:0] wr_word;
    logic [31:0] cur_word;
    fiber_select_pkg::strobe_state_t strobe_r;
    logic [1:0]  wsel_r;          // Tables chosen for the strobe
    logic [3:0]  gap_table [0:fiber_select_pkg::TABLE_DEPTH-1];
    logic [3:0]  count_table [0:fiber_select_pkg::TABLE_DEPTH-1];
    logic [15:0] gap_addr;
    logic [15:0] cnt_addr;
    logic [3:0]  gap_q_r;
    logic [3:0]  cnt_q_r;
    logic        looks_one_hit;
    logic        gap_at_limit;
    logic        fiber_none_hit;
    logic        one_hit_total;
    logic        fiber_too_many;
    logic [3:0]  verdict;
    logic [3:0]  pos_valid;
    logic [3:0]  net_verdict_qualified;
    logic        net_vote_any;
    logic        empty_any;
    logic        overflow_any;
    logic        far_pair;
    logic        split_single;
    logic        decision;
    logic [31:0] status;

    assign mode   = mode_r[fiber_select_pkg::MODE_LSB +: 3];
    assign ovf_en = mode_r[fiber_select_pkg::OVF_EN_BIT];
    // ------------------------------------------------------------
    // AXI4-Lite write channels
    // ------------------------------------------------------------
    assign wr_go = aw_held_r && w_held_r && !bvalid;
    // Address and data captured in either order
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            awready   <= 1'b1;
            wready    <= 1'b1;
        end else begin
            if (awvalid && awready) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= awaddr;
                awready   <= 1'b0;
            end
            if (wvalid && wready) begin
                w_held_r <= 1'b1;
                wdata_r  <= wdata;
                wstrb_r  <= wstrb;
                wready   <= 1'b0;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
            end
            if (bvalid && bready) begin
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Current value of the addressed register for byte merging
    always_comb begin
        unique case (awaddr_r)
            fiber_select_pkg::MODE_OFS:  cur_word = {28'h0, mode_r};
            fiber_select_pkg::ADDR_OFS:  cur_word = addr_r;
            fiber_select_pkg::DATA_OFS:  cur_word = {24'h0, data_r};
            fiber_select_pkg::DTEST_OFS: cur_word = {14'h0, dtest_r};
            default:                     cur_word = fiber_select_pkg::ZERO_WORD;
        endcase
    end

    // Byte lanes merged under the strobes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_word[8*i +: 8] = wstrb_r[i] ? wdata_r[8*i +: 8]
                                           : cur_word[8*i +: 8];
        end
    end

    // Write response, error on unmapped or read-only offsets
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= fiber_select_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            unique case (awaddr_r)
                fiber_select_pkg::MODE_OFS, fiber_select_pkg::ADDR_OFS,
                fiber_select_pkg::DATA_OFS, fiber_select_pkg::WRITE_OFS,
                fiber_select_pkg::DTEST_OFS:
                    bresp <= fiber_select_pkg::RESP_OKAY;
                default:
                    bresp <= fiber_select_pkg::RESP_SLVERR;
            endcase
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Software registers
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_r  <= 4'h0;
            addr_r  <= 32'h0000_0000;
            data_r  <= 8'h00;
            dtest_r <= 18'h00000;
        end else if (wr_go) begin
            unique case (awaddr_r)
                fiber_select_pkg::MODE_OFS:  mode_r  <= wr_word[3:0];
                fiber_select_pkg::ADDR_OFS:  addr_r  <= wr_word;
                fiber_select_pkg::DATA_OFS:  data_r  <= wr_word[7:0];
                fiber_select_pkg::DTEST_OFS: dtest_r <= wr_word[17:0];
                default: ;
            endcase
        end
    end
    // ------------------------------------------------------------
    // Table write strobe, low for one cycle then high
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_r            <= fiber_select_pkg::STROBE_IDLE;
            wsel_r              <= 2'h0;
            gap_table_write_n   <= 1'b1;
            count_table_write_n <= 1'b1;
        end else begin
            unique case (strobe_r)
                fiber_select_pkg::STROBE_IDLE: begin
                    if (wr_go && awaddr_r == fiber_select_pkg::WRITE_OFS &&
                        mode == fiber_select_pkg::MODE_LOAD &&
                        wdata_r[1:0] != 2'h0) begin
                        strobe_r            <= fiber_select_pkg::STROBE_LOW;
                        wsel_r              <= wdata_r[1:0];
                        gap_table_write_n   <= !wdata_r[0];
                        count_table_write_n <= !wdata_r[1];
                    end
                end
                fiber_select_pkg::STROBE_LOW: begin
                    strobe_r            <= fiber_select_pkg::STROBE_HIGH;
                    gap_table_write_n   <= 1'b1;
                    count_table_write_n <= 1'b1;
                end
                fiber_select_pkg::STROBE_HIGH: begin
                    strobe_r <= fiber_select_pkg::STROBE_IDLE;
                end
                default: begin
                    strobe_r <= fiber_select_pkg::STROBE_IDLE;
                end
            endcase
        end
    end
    // ------------------------------------------------------------
    // Lookup tables
    // ------------------------------------------------------------
    // Live card values in run mode, test address otherwise
    assign gap_addr = (mode == fiber_select_pkg::MODE_WORK) ?
                      card_min_gap : addr_r[15:0];
    assign cnt_addr = (mode == fiber_select_pkg::MODE_WORK) ?
                      card_hit_count : addr_r[31:16];
    // Table storage, 64k by 4 each, no reset on the arrays
    always_ff @(posedge ref_clk) begin
        if (strobe_r == fiber_select_pkg::STROBE_LOW) begin
            if (wsel_r[0]) begin
                gap_table[gap_addr] <= data_r[3:0];
            end
            if (wsel_r[1]) begin
                count_table[cnt_addr] <= data_r[7:4];
            end
        end
        gap_q_r <= gap_table[gap_addr];
        cnt_q_r <= count_table[cnt_addr];
    end

    // Table output fields; test register overrides verdicts in overall test and the decision inputs in decision test
    always_comb begin
        looks_one_hit  = gap_q_r[fiber_select_pkg::GAP_ONE_BIT];
        gap_at_limit   = gap_q_r[fiber_select_pkg::GAP_LIM_BIT];
        fiber_none_hit = cnt_q_r[fiber_select_pkg::CNT_NONE_BIT];
        one_hit_total  = cnt_q_r[fiber_select_pkg::CNT_ONE_BIT];
        fiber_too_many = cnt_q_r[fiber_select_pkg::CNT_OVR_BIT];
        verdict        = net_verdict;
        pos_valid      = {right_pos2_valid, right_pos1_valid,
                          left_pos2_valid, left_pos1_valid};
        empty_any      = left_none_hit | right_none_hit | fiber_none_hit;
        overflow_any   = left_too_many | right_too_many | fiber_too_many;
        if (mode == fiber_select_pkg::MODE_OVERALL) begin
            verdict = dtest_r[fiber_select_pkg::DT_VERD_LSB +: 4];
        end
        if (mode == fiber_select_pkg::MODE_DTEST) begin
            verdict        = dtest_r[fiber_select_pkg::DT_VERD_LSB +: 4];
            pos_valid      = dtest_r[fiber_select_pkg::DT_VAL_LSB +: 4];
            empty_any      = |dtest_r[fiber_select_pkg::DT_NONE_LSB +: 3];
            overflow_any   = |dtest_r[fiber_select_pkg::DT_OVR_LSB +: 3];
            gap_at_limit   = dtest_r[fiber_select_pkg::DT_LIM_BIT];
            looks_one_hit  = dtest_r[fiber_select_pkg::DT_ONE_BIT];
            one_hit_total  = dtest_r[fiber_select_pkg::DT_TOT_BIT];
            fiber_none_hit = dtest_r[fiber_select_pkg::DT_NONE_LSB + 2];
        end
    end
    // ------------------------------------------------------------
    // Decision logic
    // ------------------------------------------------------------
    // Verdicts qualified by left/right pairs 1/1, 1/2, 2/1, 2/2
    assign net_verdict_qualified[0] = verdict[0] & pos_valid[0] &
                                      pos_valid[2];
    assign net_verdict_qualified[1] = verdict[1] & pos_valid[0] &
                                      pos_valid[3];
    assign net_verdict_qualified[2] = verdict[2] & pos_valid[1] &
                                      pos_valid[2];
    assign net_verdict_qualified[3] = verdict[3] & pos_valid[1] &
                                      pos_valid[3];
    assign net_vote_any = |net_verdict_qualified;
    assign far_pair     = gap_at_limit & !fiber_none_hit;
    assign split_single = looks_one_hit & !one_hit_total;
    // Final decision, overflow vetoes when control bit set and forces accept when clear
    always_comb begin
        if (ovf_en) begin
            decision = net_vote_any & !(empty_any | far_pair |
                       split_single | overflow_any);
        end else begin
            decision = overflow_any | (net_vote_any & !(empty_any |
                       far_pair | split_single));
        end
    end
    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    // Mode decoded into active-low enables
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            input_buffer_enable_n <= 1'b0;
            table_output_enable_n <= 1'b0;
            picker_enable_n       <= 1'b0;
        end else begin
            input_buffer_enable_n <= mode != fiber_select_pkg::MODE_WORK;
            table_output_enable_n <= mode == fiber_select_pkg::MODE_LOAD;
            picker_enable_n <= mode == fiber_select_pkg::MODE_LOAD ||
                               mode == fiber_select_pkg::MODE_READOUT;
        end
    end

    // Only the indexed bit is set; an unknown index sets none
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            card_pick <= 4'h0;
        end else if (mode == fiber_select_pkg::MODE_WORK ||
                     mode == fiber_select_pkg::MODE_OVERALL) begin
            card_pick <= 4'h0;
            card_pick[gap_q_r[fiber_select_pkg::GAP_IDX_LSB +: 2]]
                <= 1'b1;
        end else begin
            card_pick <= 4'h0;
        end
    end

    // Decision pin, forced from test register in decision test
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            final_accept <= 1'b0;
        end else if (mode == fiber_select_pkg::MODE_DTEST) begin
            final_accept <= dtest_r[fiber_select_pkg::DT_PIN_BIT];
        end else begin
            final_accept <= decision;
        end
    end
    // ------------------------------------------------------------
    // AXI4-Lite read channel
    // ------------------------------------------------------------
    // Status word shows table data, flags and decision internals
    assign status = {9'h0, strobe_r != fiber_select_pkg::STROBE_IDLE,
                     decision, split_single, far_pair, net_vote_any,
                     overflow_any, empty_any, fiber_too_many,
                     one_hit_total, fiber_none_hit, looks_one_hit,
                     card_pick, cnt_q_r, gap_q_r};
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= fiber_select_pkg::ZERO_WORD;
            rresp   <= fiber_select_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rresp   <= fiber_select_pkg::RESP_OKAY;
            unique case (araddr)
                fiber_select_pkg::MODE_OFS:   rdata <= {28'h0, mode_r};
                fiber_select_pkg::ADDR_OFS:   rdata <= addr_r;
                fiber_select_pkg::DATA_OFS:   rdata <= {24'h0, data_r};
                fiber_select_pkg::WRITE_OFS:  rdata <= {30'h0, wsel_r};
                fiber_select_pkg::DTEST_OFS:  rdata <= {14'h0, dtest_r};
                fiber_select_pkg::STATUS_OFS: rdata <= status;
                default: begin
                    rdata <= fiber_select_pkg::ZERO_WORD;
                    rresp <= fiber_select_pkg::RESP_SLVERR;
                end
            endcase
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

endmodule : fiber_select_and_trigger_decision
`default_nettype wire

// [fiber_select_pkg.sv]
// Constants, register map and mode codes for the fibre select block
// ------------------------------------------------------------------
// ------------------------------------------------------------------
`default_nettype none
package fiber_select_pkg;
    // Register byte offsets
    localparam logic [7:0] MODE_OFS    = 8'h00;
    localparam logic [7:0] ADDR_OFS    = 8'h04;
    localparam logic [7:0] DATA_OFS    = 8'h08;
    localparam logic [7:0] WRITE_OFS   = 8'h0c;
    localparam logic [7:0] DTEST_OFS   = 8'h10;
    localparam logic [7:0] STATUS_OFS  = 8'h14;
    // Mode codes in the mode register
    localparam logic [2:0] MODE_WORK    = 3'h0;
    localparam logic [2:0] MODE_OVERALL = 3'h1;
    localparam logic [2:0] MODE_READOUT = 3'h2;
    localparam logic [2:0] MODE_LOAD    = 3'h3;
    localparam logic [2:0] MODE_DTEST   = 3'h4;
    // Mode register fields
    localparam int MODE_LSB   = 0;
    localparam int OVF_EN_BIT = 3;
    // Gap table data fields
    localparam int GAP_IDX_LSB = 0;
    localparam int GAP_ONE_BIT = 2;
    localparam int GAP_LIM_BIT = 3;
    // Count table data fields
    localparam int CNT_NONE_BIT = 0;
    localparam int CNT_ONE_BIT  = 1;
    localparam int CNT_OVR_BIT  = 2;
    // Decision test register fields
    localparam int DT_VERD_LSB = 0;
    localparam int DT_VAL_LSB  = 4;
    localparam int DT_NONE_LSB = 8;
    localparam int DT_OVR_LSB  = 11;
    localparam int DT_LIM_BIT  = 14;
    localparam int DT_ONE_BIT  = 15;
    localparam int DT_TOT_BIT  = 16;
    localparam int DT_PIN_BIT  = 17;
    // Table geometry
    localparam int TABLE_AW    = 16;
    localparam int TABLE_DEPTH = 65536;
    // Reset values and bus answers
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    // Table write strobe sequence
    typedef enum logic [1:0] {
        STROBE_IDLE = 2'b00,
        STROBE_LOW  = 2'b01,
        STROBE_HIGH = 2'b11
    } strobe_state_t;
endpackage : fiber_select_pkg
`default_nettype wire

// [fsd_chk.sv]
// Bus and output checker for the fibre select block
`default_nettype none
module fsd_chk (
    input wire logic       ref_clk,               // Clock
    input wire logic       rst_n,                 // Reset
    input wire logic       awvalid,               // Bus
    input wire logic       awready,               // Bus
    input wire logic       wvalid,                // Bus
    input wire logic       wready,                // Bus
    input wire logic       bvalid,                // Bus
    input wire logic       bready,                // Bus
    input wire logic [3:0] card_pick,             // Card select
    input wire logic       input_buffer_enable_n, // Enable
    input wire logic       table_output_enable_n, // Enable
    input wire logic       picker_enable_n,       // Enable
    input wire logic       gap_table_write_n,     // Strobe
    input wire logic       count_table_write_n    // Strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Card selection and table strobes
    pick_onehot_a: assert property ($onehot0(card_pick))
        else $error("more than one card select high");
    pick_off_a:
        assert property (picker_enable_n [*3] |-> card_pick == 4'h0)
        else $error("card select while picker off");
    gap_pulse_a:
        assert property ($fell(gap_table_write_n) |=> gap_table_write_n)
        else $error("gap table strobe not one cycle");
    cnt_pulse_a:
        assert property ($fell(count_table_write_n) |=> count_table_write_n)
        else $error("count table strobe not one cycle");
    load_only_a:
        assert property (!gap_table_write_n |-> input_buffer_enable_n
            && table_output_enable_n && picker_enable_n)
        else $error("table write outside load mode");
    // Register bus answers
    b_answer_a: assert property (awvalid && awready && wvalid && wready
        |-> ##[2:3] bvalid) else $error("write answer late");
    b_drop_a: assert property (bvalid && bready |=> !bvalid)
        else $error("write answer repeated");
    aw_block_a: assert property (bvalid |-> !awready && !wready)
        else $error("new write taken while answer pending");
endmodule : fsd_chk
`default_nettype wire

// [card_src_model.sv]
// Behavioural model of the upstream distance and network cards
`default_nettype none
module card_src_model (
    input  wire logic        ref_clk, // Clock
    input  wire logic        ev,      // New event
    input  wire logic [43:0] pat,     // Next card values
    output var  logic [43:0] outs     // Card outputs
);
    timeunit 1ns;
    timeprecision 1ps;
    // Cards hold their values steady until the next event
    initial outs = 44'h0;
    always @(posedge ref_clk) begin
        if (ev) outs <= pat;
    end
endmodule : card_src_model
`default_nettype wire

// [test_fiber_select_and_trigger_decision.sv]
// Self-checking bench for the fibre select and decision block
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; \
    $display("[ERR] %s expected %h seen %h", n, e, s); end end
module test_fiber_select_and_trigger_decision;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic [43:0] pat; logic [7:0] dat; logic ovf;
        logic [4:0] exp;} row_t;
    logic ref_clk = 1'b0, rst_n = 1'b0, ev = 1'b0, awvalid = 1'b0;
    logic wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [3:0] wstrb = 4'hf, card_pick;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [43:0] pat = 44'h0, cin;
    logic [1:0] bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid, final_accept;
    logic input_buffer_enable_n, table_output_enable_n, picker_enable_n;
    logic gap_table_write_n, count_table_write_n;
    logic [4:0] ctl;
    int n_fail = 0, n_tests = 0;
    // Pattern, table entries, overflow enable, expected pick and accept
    row_t rows [7] = '{'{44'h9335_1010_150, 8'h01, 1'b1, 5'h05},
        '{44'hfff0_0001_8f0, 8'h24, 1'b1, 5'h03},
        '{44'hff00_0011_ff0, 8'h04, 1'b1, 5'h02},
        '{44'hffff_4400_000, 8'h48, 1'b0, 5'h03},
        '{44'h2143_1111_ff4, 8'h02, 1'b1, 5'h08},
        '{44'h1234_0000_252, 8'h13, 1'b0, 5'h10},
        '{44'h5555_0000_009, 8'h10, 1'b0, 5'h03}};
    logic [4:0] en_exp [4] = '{5'h18, 5'h1c, 5'h1d, 5'h1f};
    assign ctl = {gap_table_write_n, count_table_write_n,
        input_buffer_enable_n, table_output_enable_n, picker_enable_n};
    card_src_model cards (.ref_clk, .ev, .pat, .outs(cin));
    fiber_select_and_trigger_decision dut (.*, .card_min_gap(cin[43:28]),
        .card_hit_count(cin[27:12]), .net_verdict(cin[11:8]),
        .left_pos1_valid(cin[4]), .left_pos2_valid(cin[5]),
        .right_pos1_valid(cin[6]), .right_pos2_valid(cin[7]),
        .left_none_hit(cin[0]), .right_none_hit(cin[1]),
        .left_too_many(cin[2]), .right_too_many(cin[3]));
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : results
    task automatic guard(input int i);
        if (i >= 20) begin
            `CHK("bus wait", 1'b0, 1'b1)
            results();
        end
    endtask : guard
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 20 && !(bvalid && bready); i++) begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        guard(i);
        bready <= 1'b0;
        rs = bresp;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        int i;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 20 && !(rvalid && rready); i++) begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
        end
        guard(i);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask : rdr
    // Clock at 100 MHz
    initial forever #5 ref_clk = ~ref_clk;
    // Reset, mode enables, table load, row loop, then awkward cases
    initial begin
        row_t r;
        repeat (3) @(posedge ref_clk);
        `CHK("reset outs", 10'h018, {card_pick, final_accept, ctl})
        rst_n <= 1'b1;
        foreach (en_exp[m]) begin
            wr(fiber_select_pkg::MODE_OFS, 32'(m));
            repeat (3) @(posedge ref_clk);
            `CHK("enables", en_exp[m], ctl)
        end
        foreach (rows[k]) begin
            r = rows[k];
            wr(fiber_select_pkg::ADDR_OFS, {r.pat[27:12], r.pat[43:28]});
            wr(fiber_select_pkg::DATA_OFS, 32'h40);
            wr(fiber_select_pkg::WRITE_OFS, 32'h2);
            wr(fiber_select_pkg::DATA_OFS, {24'h0, r.dat});
            wr(fiber_select_pkg::WRITE_OFS, 32'h3);
        end
        foreach (rows[k]) begin
            r = rows[k];
            wr(fiber_select_pkg::MODE_OFS, {28'h0, r.ovf, 3'h0});
            @(posedge ref_clk);
            pat <= r.pat;
            ev <= 1'b1;
            @(posedge ref_clk);
            ev <= 1'b0;
            repeat (4) @(posedge ref_clk);
            `CHK("pick accept", r.exp, {card_pick, final_accept})
        end
        wr(8'h40, 32'h1);
        `CHK("bad write", fiber_select_pkg::RESP_SLVERR, rs)
        rdr(8'h40);
        `CHK("bad read", {32'h0, fiber_select_pkg::RESP_SLVERR}, {rd, rs})
        wr(fiber_select_pkg::ADDR_OFS, 32'h1010_9335);
        wr(fiber_select_pkg::MODE_OFS, 32'(fiber_select_pkg::MODE_OVERALL));
        repeat (3) @(posedge ref_clk);
        `CHK("test pick", 4'h2, card_pick)
        wr(fiber_select_pkg::MODE_OFS, 32'(fiber_select_pkg::MODE_READOUT));
        rdr(fiber_select_pkg::STATUS_OFS);
        `CHK("table out", 8'h01, rd[7:0])
        wr(fiber_select_pkg::MODE_OFS, 32'(fiber_select_pkg::MODE_DTEST));
        wr(fiber_select_pkg::DTEST_OFS, 32'h51);
        rdr(fiber_select_pkg::STATUS_OFS);
        `CHK("decision test", 2'b10, {rd[21], final_accept})
        results();
    end
endmodule : test_fiber_select_and_trigger_decision
bind fiber_select_and_trigger_decision fsd_chk chk (.ref_clk, .rst_n,
    .awvalid, .awready, .wvalid, .wready, .bvalid, .bready, .card_pick,
    .input_buffer_enable_n, .table_output_enable_n, .picker_enable_n,
    .gap_table_write_n, .count_table_write_n);
`default_nettype wire
